/* File: ecrs_pkg.sv */
package ecrs_pkg;
	// =====================================================
	// Core clock domains, one reset each
	localparam int ECRS_NDOM = 5;
	localparam int ECRS_DOM_GT = 0;
	localparam int ECRS_DOM_PCS = 1;
	localparam int ECRS_DOM_PHY = 2;
	localparam int ECRS_DOM_LOG = 3;
	localparam int ECRS_DOM_CFG = 4;

	// =====================================================
	// Divider taps of the base counter (transceiver_clock/2, pcs = clk/4, quarter-transceiver_clock/8)
	localparam int ECRS_DIV_W = 3;
	localparam int ECRS_TAP_GT = 0;
	localparam int ECRS_TAP_PCS = 1;
	localparam int ECRS_TAP_QTR = 2;

	// =====================================================
	// Operating lane widths
	typedef enum logic [1:0] {
		ECRS_W1X = 2'b00,
		ECRS_W2X = 2'b01,
		ECRS_W4X = 2'b10
	} ecrs_width_t;

	// =====================================================
	// Reset timing
	localparam logic [2:0] ECRS_MIN_RST_CYC = 3'h4;
	localparam logic [2:0] ECRS_RST_CNT_ONE = 3'h1;
	localparam int ECRS_CLK_MHZ = 25;
	localparam int ECRS_POR_NS = 400;
	localparam int ECRS_SYS_RST_NS = 160;
	localparam logic [7:0] ECRS_POR_CYC = 8'((ECRS_POR_NS * ECRS_CLK_MHZ + 999) / 1000);
	localparam logic [7:0] ECRS_SYS_RST_CYC = 8'((ECRS_SYS_RST_NS * ECRS_CLK_MHZ + 999) / 1000);
	localparam logic [7:0] ECRS_CNT_ONE = 8'h1;

	// =====================================================
	// User-side handshake states
	typedef enum logic [2:0] {
		ECRS_ST_POR = 3'b000,
		ECRS_ST_IDLE = 3'b001,
		ECRS_ST_REQ = 3'b010,
		ECRS_ST_RST = 3'b011,
		ECRS_ST_WAIT = 3'b100
	} ecrs_state_t;
endpackage

/* File: ecrs_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ecrs_link_if;
	logic sys_rst;
	logic link_reset_req;
	logic rcvd_link_reset;
	logic port_initialized;

	// Sequencer end
	modport dev (
		input sys_rst,
		input link_reset_req,
		output rcvd_link_reset,
		output port_initialized
	);

	// User logic end
	modport usr (
		output sys_rst,
		output link_reset_req,
		input rcvd_link_reset,
		input port_initialized
	);
endinterface
`default_nettype wire

/* File: ecrs_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1 - All core clocks from one input clock
// RULE2 - Each domain reset: four cycles, synchronous release
// RULE3 - Slowed phy clock still gets four cycles
// RULE4 - Single system reset, treated as asynchronous
// RULE5 - Synchronize and stretch reset per domain
// RULE6 - User logic creates the power-up reset
// RULE7 - Report partner link reset to user
// RULE8 - User asserts system reset on received reset
// RULE9 - User holds request until port-initialized falls
// RULE10 - User then asserts system reset, completing handshake
// RULE11 - Reset both partners together, overlapping
// RULE12 - Unified: logical/config clocks are phy clock
// RULE13 - Unified traindown: logical/config follow phy rate
// RULE14 - Single-lane config: one fixed phy rate
// RULE15 - Traindown to 1x: phy is quarter gt
// RULE16 - Release link-reset request once system reset asserted
module ecrs_sequencer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire ecrs_pkg::ecrs_width_t lane_width_i,
	input wire logic single_lane_cfg_i,
	input wire logic unified_i,
	input wire logic partner_reset_i,
	output logic link_reset_tx_o,
	output logic transceiver_clock_o,
	output logic transceiver_interface_clock_o,
	output logic phy_clock_o,
	output logic log_clock_o,
	output logic cfg_clock_o,
	output logic [ecrs_pkg::ECRS_NDOM-1:0] dom_rst_o,
	ecrs_link_if.dev lnk
);
	import ecrs_pkg::*;

	// =====================================================
	// Clock generation
	logic [ECRS_DIV_W-1:0] div_r;
	logic [ECRS_DIV_W-1:0] div_nxt;
	logic [ECRS_NDOM-1:0] clk_r;
	logic [ECRS_NDOM-1:0] clk_nxt;
	logic phy_nxt;

	// Phy rate = gt * width / 4; single-lane builds never switch
	always_comb begin
		div_nxt = div_r + ECRS_DIV_W'(1);
		if (single_lane_cfg_i) begin
			phy_nxt = div_nxt[ECRS_TAP_QTR]; // RULE14
		end else begin
			case (lane_width_i)
				ECRS_W4X: phy_nxt = div_nxt[ECRS_TAP_GT];
				ECRS_W2X: phy_nxt = div_nxt[ECRS_TAP_PCS];
				ECRS_W1X: phy_nxt = div_nxt[ECRS_TAP_QTR]; // RULE15
				default: phy_nxt = div_nxt[ECRS_TAP_QTR];
			endcase
		end
		clk_nxt[ECRS_DOM_GT] = div_nxt[ECRS_TAP_GT]; // RULE1
		clk_nxt[ECRS_DOM_PCS] = div_nxt[ECRS_TAP_PCS]; // RULE1
		clk_nxt[ECRS_DOM_PHY] = phy_nxt;
		// Unified: tied to phy clock, follows its rate on traindown
		clk_nxt[ECRS_DOM_LOG] = unified_i ? phy_nxt : div_nxt[ECRS_TAP_GT]; // RULE12 RULE13
		clk_nxt[ECRS_DOM_CFG] = unified_i ? phy_nxt : div_nxt[ECRS_TAP_GT]; // RULE12 RULE13
	end

	// Divider and clock flops, free running from power-up reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_r <= '0;
			clk_r <= '0;
		end else begin
			div_r <= div_nxt;
			clk_r <= clk_nxt;
		end
	end

	// Clock outputs, each straight from its flop
	assign transceiver_clock_o = clk_r[ECRS_DOM_GT];
	assign transceiver_interface_clock_o = clk_r[ECRS_DOM_PCS];
	assign phy_clock_o = clk_r[ECRS_DOM_PHY];
	assign log_clock_o = clk_r[ECRS_DOM_LOG];
	assign cfg_clock_o = clk_r[ECRS_DOM_CFG];

	// =====================================================
	// System reset synchronizer
	logic rst_any;
	logic sync1_r;
	logic sync2_r;

	assign rst_any = rst_i | lnk.sys_rst; // RULE4

	// Asserts at once, releases after two clean edges
	always_ff @(posedge clk_i or posedge rst_any) begin
		if (rst_any) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
		end else begin
			sync1_r <= 1'b0;
			sync2_r <= sync1_r; // RULE5
		end
	end

	// =====================================================
	// Per-domain stretchers, one for each core clock
	logic [ECRS_NDOM-1:0] dom_rst_r;
	genvar gi;

	// Each domain counts its own edges, so a slowed clock still gets the full count
	generate
		for (gi = 0; gi < ECRS_NDOM; gi++) begin : g_dom
			ecrs_rst_stretch ecrs_rst_stretch_inst (
				.clk_i(clk_i),
				.rst_i(rst_any),
				.hold_i(sync2_r),
				.dom_clk_i(clk_r[gi]),
				.dom_clk_nxt_i(clk_nxt[gi]),
				.dom_rst_o(dom_rst_r[gi])
			);
		end
	endgenerate

	assign dom_rst_o = dom_rst_r;

	// =====================================================
	// Link reset handshake
	logic rcvd_r;
	logic port_init_r;
	logic tx_r;

	// Sticky received flag; a new arrival beats the clear
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rcvd_r <= 1'b0;
		end else if (partner_reset_i) begin
			rcvd_r <= 1'b1; // RULE7
		end else if (sync2_r) begin
			rcvd_r <= 1'b0;
		end
	end

	// Port drops on a request, sends one link reset, returns after phy reset
	always_ff @(posedge clk_i or posedge rst_any) begin
		if (rst_any) begin
			port_init_r <= 1'b0;
			tx_r <= 1'b0;
		end else begin
			tx_r <= 1'b0;
			if (lnk.link_reset_req && port_init_r) begin
				port_init_r <= 1'b0; // RULE9
				tx_r <= 1'b1; // RULE11
			end else if (!dom_rst_r[ECRS_DOM_PHY] && !lnk.link_reset_req) begin
				port_init_r <= 1'b1;
			end
		end
	end

	// Handshake outputs, each straight from its flop
	assign link_reset_tx_o = tx_r;
	assign lnk.rcvd_link_reset = rcvd_r;
	assign lnk.port_initialized = port_init_r;
endmodule

// =====================================================
// Reset stretcher for one clock domain
module ecrs_rst_stretch #(
	parameter logic [2:0] MIN_CYC = ecrs_pkg::ECRS_MIN_RST_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic hold_i,
	input wire logic dom_clk_i,
	input wire logic dom_clk_nxt_i,
	output logic dom_rst_o
);
	import ecrs_pkg::*;

	// =====================================================
	// Edge detection on the domain clock
	logic [2:0] cnt_r;
	logic rise;
	logic fall;

	// Edges that the next base edge will launch
	assign rise = dom_clk_nxt_i & ~dom_clk_i;
	assign fall = ~dom_clk_nxt_i & dom_clk_i;

	// =====================================================
	// Count and release
	// Held while the synchronizer is set; release on a falling edge keeps rising edges clean
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= '0;
			dom_rst_o <= 1'b1;
		end else if (hold_i) begin
			cnt_r <= '0;
			dom_rst_o <= 1'b1;
		end else if (dom_rst_o) begin
			// Counts edges of the domain's current rate, slowed or not
			if (rise && cnt_r != MIN_CYC) begin
				cnt_r <= cnt_r + ECRS_RST_CNT_ONE; // RULE2 RULE3
			end
			if (fall && cnt_r == MIN_CYC) begin
				dom_rst_o <= 1'b0; // RULE2 RULE5
			end
		end
	end
endmodule
`default_nettype wire

/* File: ecrs_user_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module ecrs_user_ctl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic send_reset_i,
	output logic app_reset_o,
	output logic busy_o,
	ecrs_link_if.usr lnk
);
	import ecrs_pkg::*;

	// =====================================================
	// Handshake state machine
	ecrs_state_t state_r;
	logic [7:0] cnt_r;
	logic sys_rst_r;
	logic req_r;
	logic pend_r;
	logic app_rst_r;

	// Sequencing of power-up, outgoing and incoming resets
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ECRS_ST_POR;
			cnt_r <= '0;
			sys_rst_r <= 1'b1;
			req_r <= 1'b0;
			app_rst_r <= 1'b1;
		end else begin
			case (state_r)
				ECRS_ST_POR: begin
					// Power-up reset comes from here
					cnt_r <= cnt_r + ECRS_CNT_ONE; // RULE6
					if (cnt_r == ECRS_POR_CYC - ECRS_CNT_ONE) begin
						sys_rst_r <= 1'b0;
						cnt_r <= '0;
						state_r <= ECRS_ST_WAIT;
					end
				end
				ECRS_ST_IDLE: begin
					if (lnk.rcvd_link_reset) begin
						sys_rst_r <= 1'b1; // RULE8
						app_rst_r <= 1'b1;
						state_r <= ECRS_ST_RST;
					end else if (pend_r || send_reset_i) begin
						req_r <= 1'b1; // RULE9 RULE11
						state_r <= ECRS_ST_REQ;
					end
				end
				ECRS_ST_REQ: begin
					// Hold request until the port drops
					if (!lnk.port_initialized) begin
						sys_rst_r <= 1'b1; // RULE10
						req_r <= 1'b0; // RULE16
						app_rst_r <= 1'b1;
						state_r <= ECRS_ST_RST;
					end
				end
				ECRS_ST_RST: begin
					cnt_r <= cnt_r + ECRS_CNT_ONE;
					if (cnt_r == ECRS_SYS_RST_CYC - ECRS_CNT_ONE) begin
						sys_rst_r <= 1'b0;
						cnt_r <= '0;
						state_r <= ECRS_ST_WAIT;
					end
				end
				ECRS_ST_WAIT: begin
					// Back in service once the port comes up again
					if (lnk.port_initialized) begin
						app_rst_r <= 1'b0;
						state_r <= ECRS_ST_IDLE;
					end
				end
				default: begin
					state_r <= ECRS_ST_POR;
				end
			endcase
		end
	end

	// Remembers a send request made while busy
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend_r <= 1'b0;
		end else if (send_reset_i && state_r != ECRS_ST_IDLE) begin
			pend_r <= 1'b1;
		end else if (state_r == ECRS_ST_IDLE) begin
			pend_r <= 1'b0;
		end
	end

	// Busy flag registered from current state, send request and received reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_o <= 1'b1;
		end else begin
			busy_o <= (state_r != ECRS_ST_IDLE) || send_reset_i || lnk.rcvd_link_reset;
		end
	end

	assign app_reset_o = app_rst_r;
	assign lnk.sys_rst = sys_rst_r;
	assign lnk.link_reset_req = req_r;
endmodule
`default_nettype wire

/* File: ecrs_link_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module ecrs_link_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sys_rst,
	input wire logic link_reset_req,
	input wire logic rcvd_link_reset,
	input wire logic port_initialized
);
	// ====================
	// Link reset handshake
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_req_drops_port: assert property (link_reset_req && port_initialized |=> !port_initialized)
		else $error("port up after request");
	a_drop_gives_rst: assert property ($fell(port_initialized) && link_reset_req |=> sys_rst)
		else $error("no reset after port drop");
	a_req_released: assert property ($rose(sys_rst) |-> !link_reset_req)
		else $error("request left up");
	a_rcvd_gives_rst: assert property (rcvd_link_reset |-> ##[0:1] sys_rst)
		else $error("no reset after received reset");
	a_rcvd_clears: assert property ($rose(rcvd_link_reset) |-> ##[2:6] !rcvd_link_reset)
		else $error("received flag stuck");
	a_port_down_rst: assert property (sys_rst |-> !port_initialized)
		else $error("port up in reset");
	a_port_wait_min: assert property ($fell(sys_rst) |-> !port_initialized [*8])
		else $error("port up too soon");
	a_port_returns: assert property ($fell(sys_rst) |-> ##[9:80] port_initialized)
		else $error("port never returned");
	// Main scenarios
	c_sent: cover property ($fell(port_initialized) && link_reset_req);
	c_rcvd: cover property ($rose(rcvd_link_reset));
	c_up: cover property ($rose(port_initialized));
endmodule
`default_nettype wire

/* File: ecrs_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ecrs_sequencer_tb;
	import ecrs_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	ecrs_width_t lane_width_i = ECRS_W4X;
	logic single_i = 1'b0;
	logic unified_i = 1'b0;
	logic partner_i = 1'b0;
	logic send_i = 1'b0;
	logic tx, gt, pcs, phy, lg, cf, app, busy;
	logic phy_q = 1'b0;
	logic [ECRS_NDOM-1:0] dom_rst;
	logic [7:0] n_gt = 8'h0, n_pcs = 8'h0, n_phy = 8'h0, n_log = 8'h0, n_cfg = 8'h0, n_rst = 8'h0, n_tx = 8'h0;
	int miscompares = 0;
	int comparisons = 0;
	int cyc = 0;
	ecrs_link_if lnk();
	ecrs_sequencer ecrs_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i), .lane_width_i(lane_width_i),
		.single_lane_cfg_i(single_i), .unified_i(unified_i), .partner_reset_i(partner_i),
		.link_reset_tx_o(tx), .transceiver_clock_o(gt), .transceiver_interface_clock_o(pcs),
		.phy_clock_o(phy), .log_clock_o(lg), .cfg_clock_o(cf), .dom_rst_o(dom_rst), .lnk(lnk));
	ecrs_user_ctl ecrs_user_ctl_inst (.clk_i(clk_i), .rst_i(rst_i), .send_reset_i(send_i),
		.app_reset_o(app), .busy_o(busy), .lnk(lnk));
	ecrs_link_chk ecrs_link_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .sys_rst(lnk.sys_rst),
		.link_reset_req(lnk.link_reset_req), .rcvd_link_reset(lnk.rcvd_link_reset),
		.port_initialized(lnk.port_initialized));
	// ====================
	// Clock, monitors, timeout
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge gt) n_gt++;
	always @(posedge pcs) n_pcs++;
	always @(posedge phy) n_phy++;
	always @(posedge lg) n_log++;
	always @(posedge cf) n_cfg++;
	// Phy rises under reset after system reset release, sampled where settled
	always @(negedge clk_i) begin
		if (phy && !phy_q && dom_rst[ECRS_DOM_PHY] && !lnk.sys_rst) n_rst++;
		phy_q = phy;
	end
	always @(posedge lnk.sys_rst) n_rst = 8'h0;
	// Release lands while phy clock is low
	always @(negedge dom_rst[ECRS_DOM_PHY]) begin
		#1 check("phy_rst_edge", 8'h0, {7'h0, phy});
	end
	always @(posedge clk_i) begin
		if (tx) n_tx++;
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			results();
		end
	end
	// ====================
	// Tasks
	task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			miscompares++;
		end
	endtask
	// Rises of each clock over 64 base cycles
	task automatic rates(input logic [7:0] e_phy, input logic [7:0] e_log);
		repeat (16) @(negedge clk_i);
		{n_gt, n_pcs, n_phy, n_log, n_cfg} = '0;
		repeat (64) @(negedge clk_i);
		check("gt", 8'h20, n_gt);
		check("pcs", 8'h10, n_pcs);
		check("phy", e_phy, n_phy);
		check("log", e_log, n_log);
		check("cfg", e_log, n_cfg);
	endtask
	task automatic wait_port(input logic v);
		for (int i = 0; i < 300 && lnk.port_initialized !== v; i++) @(negedge clk_i);
		check("port_initialized", {7'h0, v}, {7'h0, lnk.port_initialized});
	endtask
	task automatic results;
		if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ====================
	// Main sequence
	initial begin
		repeat (5) @(negedge clk_i);
		rst_i = 1'b0;
		check("dom_rst", 8'h1f, {3'h0, dom_rst});
		wait_port(1'b1);
		check("phy_rst_len", 8'h1, {7'h0, n_rst >= 8'h4});
		rates(8'h20, 8'h20);
		check("dom_rst", 8'h0, {3'h0, dom_rst});
		lane_width_i = ECRS_W2X;
		rates(8'h10, 8'h20);
		lane_width_i = ECRS_W1X;
		rates(8'h08, 8'h20);
		unified_i = 1'b1;
		rates(8'h08, 8'h08);
		lane_width_i = ECRS_W2X;
		rates(8'h10, 8'h10);
		unified_i = 1'b0;
		lane_width_i = ECRS_W4X;
		single_i = 1'b1;
		rates(8'h08, 8'h20);
		single_i = 1'b0;
		lane_width_i = ECRS_W1X;
		// Outgoing link reset under slowed phy clock
		send_i = 1'b1;
		@(negedge clk_i);
		send_i = 1'b0;
		check("busy", 8'h1, {7'h0, busy});
		wait_port(1'b0);
		wait_port(1'b1);
		repeat (2) @(negedge clk_i);
		check("tx_count", 8'h1, n_tx);
		check("phy_rst_len", 8'h1, {7'h0, n_rst >= 8'h4});
		check("req", 8'h0, {7'h0, lnk.link_reset_req});
		check("app_reset", 8'h0, {7'h0, app});
		check("busy", 8'h0, {7'h0, busy});
		check("dom_rst", 8'h0, {3'h0, dom_rst});
		// Link reset arriving from the partner
		partner_i = 1'b1;
		@(negedge clk_i);
		partner_i = 1'b0;
		check("rcvd", 8'h1, {7'h0, lnk.rcvd_link_reset});
		wait_port(1'b0);
		wait_port(1'b1);
		check("rcvd", 8'h0, {7'h0, lnk.rcvd_link_reset});
		check("phy_rst_len", 8'h1, {7'h0, n_rst >= 8'h4});
		check("tx_count", 8'h1, n_tx);
		check("dom_rst", 8'h0, {3'h0, dom_rst});
		// Asynchronous reset in mid-run, then a fresh power-up
		@(negedge clk_i);
		#5 rst_i = 1'b1;
		#1 check("dom_rst", 8'h1f, {3'h0, dom_rst});
		check("port_initialized", 8'h0, {7'h0, lnk.port_initialized});
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		wait_port(1'b1);
		check("phy_rst_len", 8'h1, {7'h0, n_rst >= 8'h4});
		results();
	end
endmodule
`default_nettype wire
